// File: hw/icd_pkg.sv
// shared constants, types and decode helpers for the interface config block
// assumes one system clock of 20 MHz and a serial link clocked by the host
package icd_pkg;

  // link command opcodes
  localparam logic [7:0] OP_RD_ANY = 8'h65;
  localparam logic [7:0] OP_WR_ANY = 8'h71;
  localparam logic [7:0] OP_WIDE_ADDR = 8'hb7;
  localparam logic [7:0] OP_SW_RESET = 8'hf0;

  // field positions inside both config registers, and the busy bit of the status register
  localparam int BIT_AL = 7;
  localparam int BIT_QA = 6;
  localparam int BIT_L3R = 5;
  localparam int BIT_RSV = 4;
  localparam int LAT_MSB = 3;
  localparam int BUSY_BIT = 0;

  // factory state of the stored register, and the bits writes may touch
  localparam logic [7:0] NV_DEFAULT = 8'h08;
  localparam logic [7:0] CFG_WMASK = 8'hef;
  localparam logic QUAD_WIDTH_DEFAULT_DEFAULT = 1'b0;

  // register addresses on the link
  localparam logic [23:0] ADDR_STATUS1V = 24'h00_0000;
  localparam logic [23:0] ADDR_CFG2NV = 24'h00_0003;
  localparam logic [23:0] ADDR_CFG2V = 24'h80_0003;

  // link cycle counts, last index of each phase
  localparam logic [5:0] LAST_BYTE_SER = 6'h07;
  localparam logic [5:0] LAST_BYTE_QUAD = 6'h01;
  localparam logic [5:0] LAST_A3_SER = 6'h17;
  localparam logic [5:0] LAST_A4_SER = 6'h1f;
  localparam logic [5:0] LAST_A3_QUAD = 6'h05;
  localparam logic [5:0] LAST_A4_QUAD = 6'h07;

  // programming time of the stored register
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_TIME_NS = 150000;
  localparam int PROG_CYCLES =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] PROG_CNT_LOAD = 12'(PROG_CYCLES - 1);

  typedef enum logic [1:0] {SEL_NONE, SEL_STATUS, SEL_NV, SEL_V} icd_sel_e;
  typedef enum logic [2:0] {
    LK_CMD, LK_ADDR, LK_DUMMY, LK_READ, LK_WRITE, LK_IDLE
  } icd_link_e;

  // register address decode, used by both domains
  function automatic icd_sel_e icd_reg_sel(input logic [23:0] a);
    icd_sel_e s;
    s = SEL_NONE;
    if (a == ADDR_STATUS1V) s = SEL_STATUS;
    if (a == ADDR_CFG2NV) s = SEL_NV;
    if (a == ADDR_CFG2V) s = SEL_V;
    return s;
  endfunction

  // one-time flip: a bit may leave its factory value once, never return
  function automatic logic [7:0] icd_otp_write(input logic [7:0] cur,
                                               input logic [7:0] wr);
    logic [7:0] flip;
    flip = (wr ^ NV_DEFAULT) & ~(cur ^ NV_DEFAULT) & CFG_WMASK;
    return cur ^ flip;
  endfunction

endpackage

// File: hw/icd_link.sv
// link front end of the interface config block, clocked by the link clock
// assumes chip select high between frames and the clock running outside them, for snapshots and reset
`timescale 1ns/100ps
module icd_link
  import icd_pkg::*;
(
  // link pins
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_n_o,
  // system reset, synchronised here
  input wire logic nrst_i,
  // register snapshot from the system domain
  input wire logic [7:0] pub_nv_i,
  input wire logic [7:0] pub_v_i,
  input wire logic pub_busy_i,
  input wire logic pub_tgl_i,
  output logic pub_ack_o,
  // command requests towards the system domain
  output logic req_tgl_o,
  output logic [7:0] req_op_o,
  output logic [23:0] req_addr_o,
  output logic [7:0] req_data_o
);

  typedef struct packed {
    icd_link_e st;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] out;
    logic [3:0] io;
    logic [3:0] oe_n;
  } icd_frame_s;

  typedef struct packed {
    logic rs1;
    logic rs2;
    logic ts1;
    logic ts2;
    logic ack;
    logic [7:0] nv;
    logic [7:0] v;
    logic busy;
    logic req_tgl;
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] data;
  } icd_keep_s;

  localparam icd_frame_s F_RESET = '{st: LK_CMD, oe_n: 4'hf, default: '0};

  icd_frame_s f, fn;
  icd_keep_s p, pn;
  logic qa;
  logic [31:0] sh_in;
  logic [5:0] last_byte;
  logic [5:0] last_addr;
  logic [7:0] ld_byte;
  logic [7:0] nb;
  logic drive;

  // frame sequencer and snapshot keeping
  always_comb begin
    fn = f;
    pn = p;
    qa = p.v[BIT_QA];
    drive = 1'b0;
    nb = 8'h00;
    // four lines per clock in four-bit mode, else one on line 0
    sh_in = qa ? {f.sh[27:0], io_i} : {f.sh[30:0], io_i[0]};
    last_byte = qa ? LAST_BYTE_QUAD : LAST_BYTE_SER;
    if (p.v[BIT_AL]) begin
      last_addr = qa ? LAST_A4_QUAD : LAST_A4_SER;
    end else begin
      last_addr = qa ? LAST_A3_QUAD : LAST_A3_SER;
    end
    // read mux; address just completing is taken from the shifter
    case (icd_reg_sel(f.st == LK_ADDR ? sh_in[23:0] : f.addr))
      SEL_STATUS: ld_byte = {7'h00, p.busy};
      SEL_NV: ld_byte = p.nv;
      SEL_V: ld_byte = p.v;
      default: ld_byte = 8'h00;
    endcase
    fn.cnt = 6'(f.cnt + 6'h01);
    case (f.st)
      LK_CMD: begin
        fn.sh = sh_in;
        if (f.cnt == last_byte) begin
          fn.op = sh_in[7:0];
          fn.cnt = 6'h00;
          fn.st = LK_IDLE;
          if (sh_in[7:0] == OP_RD_ANY || sh_in[7:0] == OP_WR_ANY) begin
            fn.st = LK_ADDR;
          end else if (sh_in[7:0] == OP_WIDE_ADDR ||
                       sh_in[7:0] == OP_SW_RESET) begin
            pn.req_tgl = ~p.req_tgl;
            pn.op = sh_in[7:0];
          end
        end
      end
      LK_ADDR: begin
        fn.sh = sh_in;
        if (f.cnt == last_addr) begin
          // top byte of a four-byte address is dropped
          fn.addr = sh_in[23:0];
          fn.cnt = 6'h00;
          if (f.op == OP_WR_ANY) begin
            fn.st = LK_WRITE;
          end else if (p.v[LAT_MSB:0] == 4'h0) begin
            fn.st = LK_READ;
            drive = 1'b1;
            nb = ld_byte;
          end else begin
            fn.st = LK_DUMMY;
          end
        end
      end
      LK_DUMMY: begin
        if (f.cnt == 6'({2'b00, p.v[LAT_MSB:0]} - 6'h01)) begin
          fn.st = LK_READ;
          fn.cnt = 6'h00;
          drive = 1'b1;
          nb = ld_byte;
        end
      end
      LK_READ: begin
        // same register repeats for as long as the host clocks
        drive = 1'b1;
        if (f.cnt == last_byte) begin
          fn.cnt = 6'h00;
          nb = ld_byte;
        end else begin
          nb = qa ? {f.out[3:0], 4'h0} : {f.out[6:0], 1'b0};
        end
      end
      LK_WRITE: begin
        fn.sh = sh_in;
        if (f.cnt == last_byte) begin
          fn.st = LK_IDLE;
          pn.req_tgl = ~p.req_tgl;
          pn.op = f.op;
          pn.addr = f.addr;
          pn.data = sh_in[7:0];
        end
      end
      LK_IDLE: fn.cnt = f.cnt;
      default: fn.st = LK_IDLE;
    endcase
    if (drive) begin
      fn.out = nb;
      fn.io = qa ? nb[7:4] : {2'b00, nb[7], 1'b0};
      fn.oe_n = qa ? 4'h0 : 4'hd;
    end
    // snapshot handshake: latch once the toggle has settled
    pn.ts1 = pub_tgl_i;
    pn.ts2 = p.ts1;
    if (p.ts2 != p.ack) begin
      pn.ack = p.ts2;
      pn.nv = pub_nv_i;
      pn.v = pub_v_i;
      pn.busy = pub_busy_i;
    end
    pn.rs1 = nrst_i;
    pn.rs2 = p.rs1;
    if (!p.rs2) begin
      // both copies start at factory value, or early reads see zeros
      pn = '{rs1: nrst_i, rs2: p.rs1, nv: NV_DEFAULT, v: NV_DEFAULT,
             default: '0};
    end
  end

  // frame state ends with the frame itself
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      f <= F_RESET;
    end else begin
      f <= fn;
    end
  end

  // state that outlives frames
  always_ff @(posedge sck_i) begin
    p <= pn;
  end

  assign io_o = f.io;
  assign io_oe_n_o = f.oe_n;
  assign pub_ack_o = p.ack;
  assign req_tgl_o = p.req_tgl;
  assign req_op_o = p.op;
  assign req_addr_o = p.addr;
  assign req_data_o = p.data;

  // dummy phase lasts exactly the configured latency
  property p_dummy_len;
    @(posedge sck_i) disable iff (cs_n_i)
    (f.st == LK_DUMMY && fn.st == LK_READ) |->
      f.cnt == 6'({2'b00, p.v[LAT_MSB:0]} - 6'h01);
  endproperty
  a_dummy_len: assert property (p_dummy_len)
    else $error("dummy phase length differs from latency");

  // four-bit reads drive all four lines
  property p_quad_drive;
    @(posedge sck_i) disable iff (cs_n_i)
    (f.st == LK_READ && p.v[BIT_QA]) |-> f.oe_n == 4'h0;
  endproperty
  a_quad_drive: assert property (p_quad_drive)
    else $error("four-bit read not driving all lines");

  // serial reads drive line 1 only
  property p_ser_drive;
    @(posedge sck_i) disable iff (cs_n_i)
    (f.st == LK_READ && !p.v[BIT_QA]) |-> f.oe_n == 4'hd;
  endproperty
  a_ser_drive: assert property (p_ser_drive)
    else $error("serial read drives wrong lines");

endmodule // icd_link

// File: hw/icd_cfg.sv
// interface config register bank: stored and working copies of the
// interface controls, reached over the serial link by register commands
// assumes the link front end in icd_link and a 20 MHz system clock
`timescale 1ns/100ps
module icd_cfg
  import icd_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic nrst_i,
  // link pins
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_n_o,
  // working controls
  output logic addr_len_4b_o,
  output logic four_bit_proto_o,
  output logic line3_reset_en_o,
  output logic [3:0] read_latency_o,
  // stored state and programming status
  output logic [7:0] interface_cfg_nonvol_o,
  output logic quad_width_default_o,
  output logic busy_o
);

  typedef struct packed {
    logic rq1;
    logic rq2;
    logic rq3;
    logic ak1;
    logic ak2;
    logic cs1;
    logic cs2;
    logic l31;
    logic l32;
    logic [7:0] nv;
    logic [7:0] v;
    logic quad_width_default;
    logic quad_v;
    logic busy;
    logic [11:0] pcnt;
    logic [7:0] pend;
    logic [7:0] pub_nv;
    logic [7:0] pub_v;
    logic pub_busy;
    logic pub_tgl;
    logic [7:0] o_nv;
    logic [7:0] o_v;
    logic o_quad_width_default;
    logic o_busy;
  } icd_cfg_s;

  localparam icd_cfg_s S_RESET = '{
    rq1: 1'b0, rq2: 1'b0, rq3: 1'b0, ak1: 1'b0, ak2: 1'b0,
    cs1: 1'b1, cs2: 1'b1, l31: 1'b1, l32: 1'b1,
    nv: NV_DEFAULT, v: NV_DEFAULT,
    quad_width_default: QUAD_WIDTH_DEFAULT_DEFAULT, quad_v: QUAD_WIDTH_DEFAULT_DEFAULT,
    pub_nv: NV_DEFAULT, pub_v: NV_DEFAULT,
    o_nv: NV_DEFAULT, o_v: NV_DEFAULT, o_quad_width_default: QUAD_WIDTH_DEFAULT_DEFAULT,
    default: '0
  };

  icd_cfg_s s, sn;
  logic req_tgl;
  logic [7:0] req_op;
  logic [23:0] req_addr;
  logic [7:0] req_data;
  logic pub_ack;
  logic req_evt;
  icd_sel_e req_sel;
  logic l3_reset;

  // link side, on its own clock
  icd_link u_link (
    .sck_i(sck_i),
    .cs_n_i(cs_n_i),
    .io_i(io_i),
    .io_o(io_o),
    .io_oe_n_o(io_oe_n_o),
    .nrst_i(nrst_i),
    .pub_nv_i(s.pub_nv),
    .pub_v_i(s.pub_v),
    .pub_busy_i(s.pub_busy),
    .pub_tgl_i(s.pub_tgl),
    .pub_ack_o(pub_ack),
    .req_tgl_o(req_tgl),
    .req_op_o(req_op),
    .req_addr_o(req_addr),
    .req_data_o(req_data)
  );

  // request fields are held by the link long after its toggle moves
  assign req_evt = s.rq2 ^ s.rq3;
  assign req_sel = icd_reg_sel(req_addr);
  // line 3 resets only while idle or not carrying quad data
  assign l3_reset = s.v[BIT_L3R] && !s.l32 && (s.cs2 || !s.quad_v);

  // register bank, programming timer and snapshot publishing
  always_comb begin
    sn = s;
    // synchronisers: first stage feeds only the second
    sn.rq1 = req_tgl;
    sn.rq2 = s.rq1;
    sn.rq3 = s.rq2;
    sn.ak1 = pub_ack;
    sn.ak2 = s.ak1;
    sn.cs1 = cs_n_i;
    sn.cs2 = s.cs1;
    sn.l31 = io_i[3];
    sn.l32 = s.l31;
    // stored copy commits when the programming time has run out
    if (s.busy) begin
      if (s.pcnt == 12'h000) begin
        sn.busy = 1'b0;
        sn.nv = s.pend;
        if (s.pend[BIT_QA]) begin
          sn.quad_width_default = 1'b1;
        end
      end else begin
        sn.pcnt = 12'(s.pcnt - 12'h001);
      end
    end
    if (req_evt) begin
      case (req_op)
        OP_WR_ANY: begin
          // writes to the stored copy are dropped while it is busy
          if (req_sel == SEL_NV && !s.busy) begin
            sn.pend = icd_otp_write(s.nv, req_data);
            sn.busy = 1'b1;
            sn.pcnt = PROG_CNT_LOAD;
          end else if (req_sel == SEL_V) begin
            sn.v = req_data & CFG_WMASK;
          end
        end
        OP_WIDE_ADDR: sn.v[BIT_AL] = 1'b1;
        OP_SW_RESET: begin
          sn.v = s.nv;
          sn.quad_v = s.quad_width_default;
        end
        default: sn.v = s.v;
      endcase
    end
    if (l3_reset) begin
      sn.v = s.nv;
      sn.quad_v = s.quad_width_default;
    end
    // publish a new snapshot only after the last one was taken
    if (s.ak2 == s.pub_tgl &&
        {s.nv, s.v, s.busy} != {s.pub_nv, s.pub_v, s.pub_busy}) begin
      sn.pub_nv = s.nv;
      sn.pub_v = s.v;
      sn.pub_busy = s.busy;
      sn.pub_tgl = ~s.pub_tgl;
    end
    // output copies keep every port on a flop
    sn.o_nv = sn.nv;
    sn.o_v = sn.v;
    sn.o_quad_width_default = sn.quad_width_default;
    sn.o_busy = sn.busy;
  end

  // power-on reset restores factory state and loads working copy
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s <= S_RESET;
    end else begin
      s <= sn;
    end
  end

  assign addr_len_4b_o = s.o_v[BIT_AL];
  assign four_bit_proto_o = s.o_v[BIT_QA];
  assign line3_reset_en_o = s.o_v[BIT_L3R];
  assign read_latency_o = s.o_v[LAT_MSB:0];
  assign interface_cfg_nonvol_o = s.o_nv;
  assign quad_width_default_o = s.o_quad_width_default;
  assign busy_o = s.o_busy;

  // changed bits never drift back to factory value
  property p_otp_once;
    @(posedge clk_i) disable iff (!nrst_i)
    ((($past(s.nv) ^ NV_DEFAULT) & ~(s.nv ^ NV_DEFAULT)) == 8'h00);
  endproperty
  a_otp_once: assert property (p_otp_once)
    else $error("stored bit returned to factory value");

  // stored four-bit protocol bit sticks at one
  property p_qa_sticky;
    @(posedge clk_i) disable iff (!nrst_i)
    $past(s.nv[BIT_QA]) |-> s.nv[BIT_QA];
  endproperty
  a_qa_sticky: assert property (p_qa_sticky)
    else $error("stored four-bit bit cleared");

  // latency bit 3 never returns to one
  property p_lat_once;
    @(posedge clk_i) disable iff (!nrst_i)
    !$past(s.nv[LAT_MSB]) |-> !s.nv[LAT_MSB];
  endproperty
  a_lat_once: assert property (p_lat_once)
    else $error("latency bit 3 restored");

  // reserved bit stays zero in both copies
  property p_rsv_zero;
    @(posedge clk_i) disable iff (!nrst_i)
    !s.nv[BIT_RSV] && !s.v[BIT_RSV];
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved bit set");

  // storing four-bit protocol drags quad width default along
  property p_quad_follow;
    @(posedge clk_i) disable iff (!nrst_i)
    $rose(s.nv[BIT_QA]) |-> s.quad_width_default;
  endproperty
  a_quad_follow: assert property (p_quad_follow)
    else $error("quad width default not stored");

  // working write lands one cycle after the settled request
  sequence q_wr_v;
    req_evt && req_op == OP_WR_ANY && req_sel == SEL_V && !l3_reset;
  endsequence
  property p_wr_v;
    @(posedge clk_i) disable iff (!nrst_i)
    q_wr_v |=> s.v == ($past(req_data) & CFG_WMASK) ##1
      four_bit_proto_o == s.v[BIT_QA];
  endproperty
  a_wr_v: assert property (p_wr_v)
    else $error("working register write not applied");

  // wide address command sets address length
  property p_wide;
    @(posedge clk_i) disable iff (!nrst_i)
    (req_evt && req_op == OP_WIDE_ADDR && !l3_reset) |=> s.v[BIT_AL]
      ##1 addr_len_4b_o;
  endproperty
  a_wide: assert property (p_wide)
    else $error("wide address command ignored");

  // line 3 reset reloads the working copy from the stored one
  property p_l3_load;
    @(posedge clk_i) disable iff (!nrst_i)
    l3_reset |=> s.v == $past(s.nv) && s.quad_v == $past(s.quad_width_default);
  endproperty
  a_l3_load: assert property (p_l3_load)
    else $error("line 3 reset did not reload controls");

  // software reset reloads the working copy from the stored one
  property p_sw_load;
    @(posedge clk_i) disable iff (!nrst_i)
    (req_evt && req_op == OP_SW_RESET && !l3_reset) |=>
      s.v == $past(s.nv) && s.quad_v == $past(s.quad_width_default);
  endproperty
  a_sw_load: assert property (p_sw_load)
    else $error("software reset did not reload controls");

  // a stored write starts the full programming time
  sequence q_nv_start;
    req_evt && req_op == OP_WR_ANY && req_sel == SEL_NV && !s.busy;
  endsequence
  property p_prog_start;
    @(posedge clk_i) disable iff (!nrst_i)
    q_nv_start |=> s.busy && s.pcnt == PROG_CNT_LOAD;
  endproperty
  a_prog_start: assert property (p_prog_start)
    else $error("stored write did not start programming");

  // a stored write that arrives while busy leaves the pending value
  property p_busy_drop;
    @(posedge clk_i) disable iff (!nrst_i)
    (req_evt && req_op == OP_WR_ANY && req_sel == SEL_NV && s.busy) |=>
      s.pend == $past(s.pend);
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("stored write accepted while busy");

  // stored copy only moves when programming ends
  property p_nv_commit;
    @(posedge clk_i) disable iff (!nrst_i)
    (s.nv != $past(s.nv)) |-> $past(s.busy) && !s.busy;
  endproperty
  a_nv_commit: assert property (p_nv_commit)
    else $error("stored copy changed outside programming");

endmodule // icd_cfg

// File: testbench/icd_host_model.sv
// host side of the serial link: drives clock, select and data lines
// assumes the device samples on rising edges and answers just after them
`timescale 1ns/100ps
module icd_host_model
  import icd_pkg::*;
(
  // link pins seen from the host
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  // device drive of the lines
  input wire logic [3:0] dev_io_i,
  input wire logic [3:0] dev_oe_n_i
);
  localparam int HALF = 40;
  logic quad;
  logic [3:0] drv_v;
  logic [3:0] drv_oe;

  // wire level per line; a floating line shows the inverse, not a kind 0
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (drv_oe[k]) io_o[k] = drv_v[k];
      else if (!dev_oe_n_i[k]) io_o[k] = dev_io_i[k];
      else io_o[k] = ~dev_io_i[k];
    end
  end

  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    quad = 1'b0;
    drv_v = 4'hf;
    drv_oe = 4'hf;
  end

  // one clock: drive after the fall, sample just before the rise
  task automatic unit(input logic [3:0] v, inout logic [7:0] got);
    sck_o = 1'b0;
    if (quad) drv_v = v;
    else drv_v[0] = v[0];
    #(HALF);
    got = quad ? {got[3:0], io_o} : {got[6:0], io_o[1]};
    sck_o = 1'b1;
    #(HALF);
  endtask

  // msb first, one or four bits per clock
  task automatic send(input logic [31:0] v, input int n);
    logic [7:0] g;
    g = 8'h00;
    for (int i = n - 1; i >= 0; i -= (quad ? 4 : 1)) begin
      if (quad) unit(v[i -: 4], g);
      else unit({3'b000, v[i]}, g);
    end
  endtask

  // line 1 is the device's in serial mode
  task automatic open_frame();
    drv_oe = quad ? 4'hf : 4'hd;
    cs_n_o = 1'b0;
  endtask

  // lines 2 and 3 held high so line 3 never looks like a reset
  task automatic close_frame();
    sck_o = 1'b0;
    #(HALF);
    cs_n_o = 1'b1;
    drv_oe = 4'hf;
    drv_v = 4'hf;
    #(HALF);
  endtask

  task automatic rd(input logic [31:0] a, input int nb, input int lat,
                    output logic [7:0] d, output logic [3:0] oe);
    logic [7:0] g;
    g = 8'h00;
    open_frame();
    send({24'h00_0000, OP_RD_ANY}, 8);
    send(a, nb * 8);
    if (quad) drv_oe = 4'h0;
    repeat (lat) unit(4'h0, g);
    d = 8'h00;
    repeat (quad ? 2 : 8) unit(4'h0, d);
    oe = dev_oe_n_i;
    close_frame();
  endtask

  task automatic wr(input logic [31:0] a, input int nb, input logic [7:0] d);
    open_frame();
    send({24'h00_0000, OP_WR_ANY}, 8);
    send(a, nb * 8);
    send({24'h00_0000, d}, 8);
    close_frame();
  endtask

  task automatic cmd(input logic [7:0] op);
    open_frame();
    send({24'h00_0000, op}, 8);
    close_frame();
  endtask

  // clocks with select high, so mode changes reach the link side
  task automatic idle(input int n);
    repeat (n) begin
      sck_o = 1'b1;
      #(HALF);
      sck_o = 1'b0;
      #(HALF);
    end
  endtask

  // pull line 3 low between frames
  task automatic line3(input int ns);
    drv_v[3] = 1'b0;
    #(ns);
    drv_v[3] = 1'b1;
  endtask
endmodule // icd_host_model

// File: testbench/tb_interface_config_defaults.sv
// self-checking bench for the interface config register bank
// assumes icd_host_model as the link host and a 50 ns system clock
`timescale 1ns/100ps
module tb_interface_config_defaults;
  import icd_pkg::*;
  logic clk_i;
  logic nrst_i;
  logic sck;
  logic cs_n;
  logic [3:0] io_w;
  logic [3:0] io_d;
  logic [3:0] oe_n;
  logic addr_len_4b_o;
  logic four_bit_proto_o;
  logic line3_reset_en_o;
  logic [3:0] read_latency_o;
  logic [7:0] interface_cfg_nonvol_o;
  logic quad_width_default_o;
  logic busy_o;
  logic [7:0] rd_v;
  logic [3:0] oe_v;
  int n_mismatch;
  int n_tests;

  icd_cfg i_dut (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .sck_i(sck),
    .cs_n_i(cs_n),
    .io_i(io_w),
    .io_o(io_d),
    .io_oe_n_o(oe_n),
    .addr_len_4b_o(addr_len_4b_o),
    .four_bit_proto_o(four_bit_proto_o),
    .line3_reset_en_o(line3_reset_en_o),
    .read_latency_o(read_latency_o),
    .interface_cfg_nonvol_o(interface_cfg_nonvol_o),
    .quad_width_default_o(quad_width_default_o),
    .busy_o(busy_o)
  );

  icd_host_model i_host (
    .sck_o(sck),
    .cs_n_o(cs_n),
    .io_o(io_w),
    .dev_io_i(io_d),
    .dev_oe_n_i(oe_n)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // working controls packed like the register, reserved bit as zero
  task automatic chk_ctl(input logic [7:0] exp);
    chk("working", {addr_len_4b_o, four_bit_proto_o, line3_reset_en_o,
                    1'b0, read_latency_o}, exp);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a,
                        input int nb, input int lat, input logic [7:0] exp,
                        input logic [3:0] oe_exp);
    i_host.rd(a, nb, lat, rd_v, oe_v);
    chk(what, rd_v, exp);
    chk({what, " oe"}, {4'h0, oe_v}, {4'h0, oe_exp});
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // status polling; a stuck busy bit would otherwise hang the run
  task automatic prog_wait(input int lat);
    int k;
    k = 0;
    do begin
      i_host.rd({8'h00, ADDR_STATUS1V}, 3, lat, rd_v, oe_v);
      k++;
    end while (rd_v[BUSY_BIT] !== 1'b0 && k < 200);
    if (rd_v[BUSY_BIT] !== 1'b0) begin
      n_mismatch++;
      $display("unexpected busy still set after polling");
      test_done();
    end
  endtask

  initial begin
    nrst_i = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    #10;
    // link side syncs reset on the link clock, so it must toggle now
    i_host.idle(6);
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    i_host.idle(4);
    chk("stored", interface_cfg_nonvol_o, 8'h08);
    chk_ctl(8'h08);
    chk("flags", {6'h00, quad_width_default_o, busy_o}, 8'h00);
    rd_chk("nv", {8'h00, ADDR_CFG2NV}, 3, 8, 8'h08, 4'hd);
    i_host.wr(32'h0000_0010, 3, 8'hff);
    i_host.wr({8'h00, ADDR_CFG2V}, 3, 8'h93);
    i_host.idle(4);
    chk_ctl(8'h83);
    rd_chk("v4", 32'ha580_0003, 4, 3, 8'h83, 4'hd);
    i_host.cmd(OP_SW_RESET);
    i_host.idle(4);
    chk_ctl(8'h08);
    i_host.cmd(OP_WIDE_ADDR);
    i_host.idle(4);
    chk_ctl(8'h88);
    i_host.cmd(OP_SW_RESET);
    i_host.idle(4);
    // store new boot defaults, then try to restore the factory value
    i_host.wr({8'h00, ADDR_CFG2NV}, 3, 8'h61);
    // second stored write lands while busy and must be dropped
    i_host.wr({8'h00, ADDR_CFG2NV}, 3, 8'he8);
    i_host.idle(8);
    chk("busy", {7'h00, busy_o}, 8'h01);
    prog_wait(8);
    chk("stored", interface_cfg_nonvol_o, 8'h61);
    chk("quad dflt", {7'h00, quad_width_default_o}, 8'h01);
    i_host.wr({8'h00, ADDR_CFG2NV}, 3, 8'h08);
    i_host.idle(8);
    prog_wait(8);
    chk("stored", interface_cfg_nonvol_o, 8'h61);
    // quad width comes back set, so four-bit use is legal
    i_host.cmd(OP_SW_RESET);
    i_host.idle(4);
    chk_ctl(8'h61);
    i_host.quad = 1'b1;
    rd_chk("vq", {8'h00, ADDR_CFG2V}, 3, 1, 8'h61, 4'h0);
    i_host.wr({8'h00, ADDR_CFG2V}, 3, 8'h64);
    i_host.idle(4);
    chk_ctl(8'h64);
    i_host.line3(500);
    i_host.idle(4);
    chk_ctl(8'h61);
    i_host.wr({8'h00, ADDR_CFG2V}, 3, 8'h21);
    i_host.quad = 1'b0;
    i_host.idle(4);
    chk_ctl(8'h21);
    rd_chk("nv ser", {8'h00, ADDR_CFG2NV}, 3, 1, 8'h61, 4'hd);
    i_host.wr({8'h00, ADDR_CFG2V}, 3, 8'h20);
    i_host.idle(4);
    rd_chk("v lat0", {8'h00, ADDR_CFG2V}, 3, 0, 8'h20, 4'hd);
    i_host.wr({8'h00, ADDR_CFG2V}, 3, 8'h44);
    i_host.quad = 1'b1;
    i_host.idle(4);
    rd_chk("vq2", {8'h00, ADDR_CFG2V}, 3, 4, 8'h44, 4'h0);
    i_host.line3(500);
    i_host.idle(4);
    chk_ctl(8'h44);
    test_done();
  end
endmodule // tb_interface_config_defaults
